// ---- rtl/mode_port_pins.sv ----
/*
  Parallel port pin logic: ports A to E, the low address port and the
  shared read/write pin, with mode dependent bus functions.
  Assumes synchronous inputs on one clock, the mode pins stable during
  reset, and timer, serial and bus cores beside it supplying their drives.
*/
`timescale 1ns/1ns

module mode_port_pins
  import port_pins_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic [1:0]          mode_pins,
  // Register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output      logic [7:0]          reg_rdata,
  // Pin levels
  input  wire logic [PORT_W-1:0]   timer_port_pin_in,
  input  wire logic [PORT_W-1:0]   high_address_port_pin_in,
  input  wire logic [PORT_W-1:0]   data_bus_port_pin_in,
  input  wire logic [SERIAL_W-1:0] serial_port_pin_in,
  input  wire logic [PORT_W-1:0]   analog_port_pin_in,
  input  wire logic                shared_read_write_pin_in,
  // Pin drives
  output      pin_drive_t          timer_port_drive,
  output      pin_drive_t          high_address_port_drive,
  output      pin_drive_t          data_bus_port_drive,
  output      pin_drive_t          low_address_port_drive,
  output      serial_drive_t       serial_port_drive,
  output      bit_drive_t          shared_read_write_drive,
  output      logic                high_address_pullup_en,
  // Timer side
  input  wire logic [PORT_W-1:0]   timer_compare_en,
  input  wire logic [PORT_W-1:0]   timer_compare_level,
  output      logic [PORT_W-1:0]   timer_capture_level,
  // Serial and SPI side
  input  wire serial_drive_t       serial_alt_drive,
  input  wire logic [SERIAL_W-1:0] serial_alt_en,
  output      logic [SERIAL_W-1:0] serial_alt_level,
  // Converter side
  output      logic [PORT_W-1:0]   analog_level,
  // External bus side
  input  wire logic                bus_active,
  input  wire logic                bus_read_cycle,
  input  wire logic [15:0]         bus_address,
  input  wire logic [7:0]          bus_wdata,
  output      logic [7:0]          bus_rdata
);

  ////////////////////////////////////////////////////////////////////
  // Mode and registers
  op_mode_t            mode_reg;           // Mode caught during reset
  logic                bus_mode;           // Expanded or test
  logic                single_mode;        // Single chip only
  logic [PORT_W-1:0]   a_data_reg;         // Port A latch
  logic [PORT_W-1:0]   a_dir_reg;          // Port A direction
  logic [PORT_W-1:0]   b_data_reg;         // Port B latch
  logic [PORT_W-1:0]   b_dir_reg;          // Port B direction
  logic [PORT_W-1:0]   c_data_reg;         // Port C latch
  logic [PORT_W-1:0]   c_dir_reg;          // Port C direction
  logic [SERIAL_W-1:0] d_data_reg;         // Port D latch
  logic [SERIAL_W-1:0] d_dir_reg;          // Port D direction
  logic                g_data_reg;         // Shared pin latch
  logic                g_dir_reg;          // Shared pin direction
  logic                open_drain_reg;     // Port C open drain select
  logic                pullup_b_reg;       // Port B pull-up enable
  pin_drive_t          a_next;             // Port A drive next
  pin_drive_t          b_next;             // Port B drive next
  pin_drive_t          c_next;             // Port C drive next
  pin_drive_t          f_next;             // Low address drive next
  serial_drive_t       d_next;             // Port D drive next
  bit_drive_t          g_next;             // Shared pin drive next
  logic [7:0]          rdata_next;         // Read data next

  assign bus_mode    = (mode_reg == MODE_EXPANDED) || (mode_reg == MODE_TEST);
  assign single_mode = (mode_reg == MODE_SINGLE);

  // Mode pins are sampled while reset is held
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mode_reg <= op_mode_t'(mode_pins);
    end
  end

  // Data latches take every write regardless of direction or mode
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      a_data_reg <= DATA_RESET;
      b_data_reg <= DATA_RESET;
      c_data_reg <= DATA_RESET;
      d_data_reg <= DATA_RESET[SERIAL_W-1:0];
      g_data_reg <= 1'b0;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        OFS_A_DATA: a_data_reg <= reg_wdata;
        OFS_B_DATA: b_data_reg <= reg_wdata;
        OFS_C_DATA: c_data_reg <= reg_wdata;
        OFS_D_DATA: d_data_reg <= reg_wdata[SERIAL_W-1:0];
        OFS_G_DATA: g_data_reg <= reg_wdata[G_RW_BIT];
        default:    ;
      endcase
    end
  end

  // Direction registers: one selects output, all clear at reset
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      a_dir_reg <= DIR_RESET;
      b_dir_reg <= DIR_RESET;
      c_dir_reg <= DIR_RESET;
      d_dir_reg <= DIR_RESET[SERIAL_W-1:0];
      g_dir_reg <= 1'b0;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        OFS_A_DIR: a_dir_reg <= reg_wdata;
        OFS_B_DIR: b_dir_reg <= reg_wdata;
        OFS_C_DIR: c_dir_reg <= reg_wdata;
        OFS_D_DIR: d_dir_reg <= reg_wdata[SERIAL_W-1:0];
        OFS_G_DIR: g_dir_reg <= reg_wdata[G_RW_BIT];
        default:   ;
      endcase
    end
  end

  // Option bits: open drain select and port B pull-ups
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      open_drain_reg <= 1'b0;
      pullup_b_reg   <= 1'b0;
    end
    else if (reg_write && (reg_addr == OFS_OPTION))
    begin
      open_drain_reg <= reg_wdata[OPT_OPEN_DRAIN];
      pullup_b_reg   <= reg_wdata[OPT_PULLUP_B];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drive selection
  genvar i;

  // Port A: compare pins follow the timer, others the direction
  generate
    for (i = 0; i < PORT_W; i++)
    begin : g_port_a
      logic oc_own;                                           // Timer owns this pin
      assign oc_own       = timer_compare_en[i] && TIMER_OC_MASK[i];
      assign a_next.oe[i]  = oc_own ? 1'b1 : a_dir_reg[i];
      assign a_next.out[i] = oc_own ? timer_compare_level[i] : a_data_reg[i];
    end
  endgenerate

  // Port D: enabled serial function overrides the latch
  generate
    for (i = 0; i < SERIAL_W; i++)
    begin : g_port_d
      assign d_next.oe[i]  = serial_alt_en[i] ? serial_alt_drive.oe[i] : d_dir_reg[i];
      assign d_next.out[i] = serial_alt_en[i] ? serial_alt_drive.out[i] : d_data_reg[i];
    end
  endgenerate

  // Ports B, C, low address and the shared pin by mode
  always_comb
  begin
    if (bus_mode)
    begin
      b_next.out = bus_address[15:8];
      b_next.oe  = ALL_ONES;
      f_next.out = bus_address[7:0];
      f_next.oe  = ALL_ONES;
      c_next.out = bus_wdata;
      c_next.oe  = (bus_active && !bus_read_cycle) ? ALL_ONES : ZERO_BYTE;
      g_next.out = !(bus_active && !bus_read_cycle);
      g_next.oe  = 1'b1;
    end
    else
    begin
      b_next.out = b_data_reg;
      b_next.oe  = b_dir_reg;
      f_next.out = ZERO_BYTE;
      f_next.oe  = ZERO_BYTE;
      if (open_drain_reg && single_mode)
      begin
        c_next.out = ZERO_BYTE;
        c_next.oe  = c_dir_reg & ~c_data_reg;
      end
      else
      begin
        c_next.out = c_data_reg;
        c_next.oe  = c_dir_reg;
      end
      g_next.out = g_data_reg;
      g_next.oe  = g_dir_reg;
    end
  end

  // Drive outputs come from flip-flops; all released at reset
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      timer_port_drive        <= '0;
      high_address_port_drive <= '0;
      data_bus_port_drive     <= '0;
      low_address_port_drive  <= '0;
      serial_port_drive       <= '0;
      shared_read_write_drive <= '0;
      high_address_pullup_en  <= 1'b0;
    end
    else
    begin
      timer_port_drive        <= a_next;
      high_address_port_drive <= b_next;
      data_bus_port_drive     <= c_next;
      low_address_port_drive  <= f_next;
      serial_port_drive       <= d_next;
      shared_read_write_drive <= g_next;
      high_address_pullup_en  <= pullup_b_reg;
    end
  end

  // Peripheral views of the pins; port E is input only
  assign timer_capture_level = timer_port_pin_in;
  assign serial_alt_level    = serial_port_pin_in;
  assign analog_level        = analog_port_pin_in;
  assign bus_rdata           = data_bus_port_pin_in;

  ////////////////////////////////////////////////////////////////////
  // Register reads
  // Input bits show the pin, output bits the driver input
  function automatic logic [7:0] pin_view(input logic [7:0] oe, input logic [7:0] drv,
                                          input logic [7:0] pin);
    pin_view = (oe & drv) | (~oe & pin);
  endfunction

  always_comb
  begin
    case (reg_addr)
      OFS_A_DATA: rdata_next = pin_view(a_next.oe, a_next.out, timer_port_pin_in);
      OFS_A_DIR:  rdata_next = a_dir_reg;
      OFS_B_DATA: rdata_next = pin_view(b_next.oe, b_next.out, high_address_port_pin_in);
      OFS_B_DIR:  rdata_next = b_dir_reg;
      OFS_C_DATA: rdata_next = pin_view(c_next.oe, c_next.out, data_bus_port_pin_in);
      OFS_C_DIR:  rdata_next = c_dir_reg;
      OFS_D_DATA: rdata_next = {2'b00, (d_next.oe & d_next.out) | (~d_next.oe & serial_port_pin_in)};
      OFS_D_DIR:  rdata_next = {2'b00, d_dir_reg};
      OFS_E_DATA: rdata_next = analog_port_pin_in;
      OFS_G_DATA: rdata_next = {(g_next.oe ? g_next.out : shared_read_write_pin_in), 7'h00};
      OFS_G_DIR:  rdata_next = {g_dir_reg, 7'h00};
      OFS_OPTION: rdata_next = {6'h00, pullup_b_reg, open_drain_reg};
      OFS_MODE:   rdata_next = {6'h00, mode_reg};
      default:    rdata_next = ZERO_BYTE;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      reg_rdata <= ZERO_BYTE;
    end
    else
    begin
      reg_rdata <= reg_read ? rdata_next : ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_rw_read_high: assert property (bus_mode && bus_active && bus_read_cycle |=>
    shared_read_write_drive.oe && shared_read_write_drive.out)
    else $error("read/write pin not high on read");
  a_rw_write_low: assert property (bus_mode && bus_active && !bus_read_cycle |=>
    shared_read_write_drive.oe && !shared_read_write_drive.out)
    else $error("read/write pin not low on write");
  a_high_addr_out: assert property (bus_mode |=> high_address_port_drive.out == $past(bus_address[15:8])
    && high_address_port_drive.oe == ALL_ONES)
    else $error("high address not on port B");
  a_low_addr_out: assert property (bus_mode |=> low_address_port_drive.out == $past(bus_address[7:0]))
    else $error("low address not driven");
  a_b_gpio_drive: assert property (!bus_mode |=> high_address_port_drive.oe == $past(b_dir_reg))
    else $error("port B enable not from direction");
  a_c_open_drain: assert property (single_mode && open_drain_reg |=>
    data_bus_port_drive.out == ZERO_BYTE && (data_bus_port_drive.oe & $past(c_data_reg)) == ZERO_BYTE)
    else $error("open drain port C drives high");
  a_oc_holds_pin: assert property (timer_compare_en[4] && reg_write && reg_addr == OFS_A_DATA
    ##1 timer_compare_en[4] |=> timer_port_drive.out[4] == $past(timer_compare_level[4]))
    else $error("port A write reached compare pin");
  a_dir_reset: assert property ($fell(sys_rst) |-> a_dir_reg == DIR_RESET && timer_port_drive.oe == ZERO_BYTE)
    else $error("direction not cleared by reset");
  a_d_gpio_only: assert property (!serial_alt_en[0] && !d_dir_reg[0] |=> !serial_port_drive.oe[0])
    else $error("port D input pin driven");
  a_read_latency: assert property (reg_read && reg_addr == OFS_E_DATA |=> reg_rdata == $past(analog_port_pin_in))
    else $error("port E read wrong");

  c_bus_write: cover property (bus_mode && bus_active && !bus_read_cycle ##1 bus_active && bus_read_cycle);
  c_open_drain: cover property (single_mode && open_drain_reg && c_dir_reg != ZERO_BYTE);
  c_oc_write: cover property (timer_compare_en[5] && reg_write && reg_addr == OFS_A_DATA);
  c_serial_alt: cover property (serial_alt_en[1] && d_dir_reg[1]);

endmodule

// ---- rtl/port_pins_pkg.sv ----
/*
  Constants and types for the mode dependent port pin block.
  Assumes one clock domain and a plain byte-wide register port.
*/
package port_pins_pkg;

  // Operating modes, caught from the mode pins during reset
  typedef enum logic [1:0]
  {
    MODE_SINGLE   = 2'b00,
    MODE_EXPANDED = 2'b01,
    MODE_BOOT     = 2'b10,
    MODE_TEST     = 2'b11
  } op_mode_t;

  localparam int PORT_W   = 8;  // Width of a full port
  localparam int SERIAL_W = 6;  // Width of the serial port
  localparam int ADDR_W   = 8;  // Register address width

  // Register offsets
  localparam logic [7:0] OFS_A_DATA   = 8'h00;
  localparam logic [7:0] OFS_A_DIR    = 8'h01;
  localparam logic [7:0] OFS_B_DATA   = 8'h02;
  localparam logic [7:0] OFS_B_DIR    = 8'h03;
  localparam logic [7:0] OFS_C_DATA   = 8'h04;
  localparam logic [7:0] OFS_C_DIR    = 8'h05;
  localparam logic [7:0] OFS_D_DATA   = 8'h06;
  localparam logic [7:0] OFS_D_DIR    = 8'h07;
  localparam logic [7:0] OFS_E_DATA   = 8'h08;
  localparam logic [7:0] OFS_G_DATA   = 8'h09;
  localparam logic [7:0] OFS_G_DIR    = 8'h0A;
  localparam logic [7:0] OFS_OPTION   = 8'h0B;
  localparam logic [7:0] OFS_MODE     = 8'h0C;

  // Field positions in the option and shared pin registers
  localparam int OPT_OPEN_DRAIN = 0;
  localparam int OPT_PULLUP_B   = 1;
  localparam int G_RW_BIT       = 7;

  // Reset values
  localparam logic [7:0] DIR_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [7:0] ALL_ONES   = 8'hFF;

  // Port A bits that can carry a timer output compare
  localparam logic [7:0] TIMER_OC_MASK = 8'hF8;

  // One driven pin group: level and enable
  typedef struct packed
  {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } pin_drive_t;

  // Serial port pin group
  typedef struct packed
  {
    logic [SERIAL_W-1:0] out;
    logic [SERIAL_W-1:0] oe;
  } serial_drive_t;

  // Single pin
  typedef struct packed
  {
    logic out;
    logic oe;
  } bit_drive_t;

endpackage

// ---- bench/pin_world.sv ----
/*
  Far side of the port pins: resolves each pin level from the block's drive
  and the level that outside circuitry offers when the block lets go.
  Assumes the bench supplies outside levels that differ from the last driven value.
*/
`timescale 1ns/1ns

module pin_world
  import port_pins_pkg::*;
(
  input  wire pin_drive_t          drv_a,
  input  wire pin_drive_t          drv_b,
  input  wire pin_drive_t          drv_c,
  input  wire serial_drive_t       drv_d,
  input  wire bit_drive_t          drv_g,
  input  wire logic                pu_en,
  input  wire logic [PORT_W-1:0]   ext_a,
  input  wire logic [PORT_W-1:0]   ext_b,
  input  wire logic [PORT_W-1:0]   ext_c,
  input  wire logic [SERIAL_W-1:0] ext_d,
  input  wire logic                ext_g,
  output      logic [PORT_W-1:0]   pin_a,
  output      logic [PORT_W-1:0]   pin_b,
  output      logic [PORT_W-1:0]   pin_c,
  output      logic [SERIAL_W-1:0] pin_d,
  output      logic                pin_g
);
  ////////////////////////////////////////////////////////////////////////////
  // Driven bits follow the block, released bits follow outside circuitry
  assign pin_a = (drv_a.oe & drv_a.out) | (~drv_a.oe & ext_a);
  // Released port B bits rise when the pull-ups are on
  assign pin_b = (drv_b.oe & drv_b.out) | (~drv_b.oe & (pu_en ? ALL_ONES : ext_b));
  assign pin_c = (drv_c.oe & drv_c.out) | (~drv_c.oe & ext_c);
  assign pin_d = (drv_d.oe & drv_d.out) | (~drv_d.oe & ext_d);
  assign pin_g = drv_g.oe ? drv_g.out : ext_g;
endmodule

// ---- bench/mode_port_pins_test.sv ----
/*
  Self-checking bench for the mode dependent port pins, driven through the
  byte register port. Assumes the pin_world model closes the pin loop.
*/
`timescale 1ns/1ns

module mode_port_pins_test;
  import port_pins_pkg::*;
  logic          clock, sys_rst, reg_write, reg_read, ext_g, pin_g, pu_en, bus_act, bus_rdc;
  logic [1:0]    mode_pins;
  logic [7:0]    reg_addr, reg_wdata, reg_rdata, ext_a, ext_b, ext_c, ext_e, pin_a, pin_b, pin_c;
  logic [7:0]    tc_en, tc_lvl, cap_lvl, an_lvl, bus_rd, bus_wd;
  logic [5:0]    ext_d, pin_d, s_en, s_lvl;
  logic [15:0]   bus_addr;
  pin_drive_t    drv_a, drv_b, drv_c, drv_l;
  serial_drive_t drv_d, s_alt;
  bit_drive_t    drv_g;
  int            error_cnt, compares;

  mode_port_pins u_dut (.clock(clock), .sys_rst(sys_rst), .mode_pins(mode_pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_port_pin_in(pin_a), .high_address_port_pin_in(pin_b), .data_bus_port_pin_in(pin_c),
    .serial_port_pin_in(pin_d), .analog_port_pin_in(ext_e), .shared_read_write_pin_in(pin_g),
    .timer_port_drive(drv_a), .high_address_port_drive(drv_b), .data_bus_port_drive(drv_c),
    .low_address_port_drive(drv_l), .serial_port_drive(drv_d), .shared_read_write_drive(drv_g),
    .high_address_pullup_en(pu_en), .timer_compare_en(tc_en), .timer_compare_level(tc_lvl),
    .timer_capture_level(cap_lvl), .serial_alt_drive(s_alt), .serial_alt_en(s_en),
    .serial_alt_level(s_lvl), .analog_level(an_lvl), .bus_active(bus_act), .bus_read_cycle(bus_rdc),
    .bus_address(bus_addr), .bus_wdata(bus_wd), .bus_rdata(bus_rd));

  pin_world u_world (.drv_a(drv_a), .drv_b(drv_b), .drv_c(drv_c), .drv_d(drv_d), .drv_g(drv_g),
    .pu_en(pu_en), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c), .ext_d(ext_d), .ext_g(ext_g),
    .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d), .pin_g(pin_g));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 8 ns
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and run control
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data are looked at in the one cycle where they stand
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Let registered drives catch up with their cause
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clock);
    sys_rst   <= 1'b1;
    mode_pins <= m;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the 130 or so cycles the sequence needs
  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    // Reset is held from time zero so no state is unknown at the first edge
    {sys_rst, reg_write, reg_read, bus_act, bus_rdc, ext_g} = 6'h20;
    {mode_pins, reg_addr, reg_wdata, tc_en, tc_lvl, bus_wd, s_en, s_alt} = '0;
    {ext_a, ext_b, ext_c, ext_e, ext_d, bus_addr} = {8'h3C, 8'h5A, 8'hA5, 8'h96, 6'h15, 16'h0000};
    error_cnt = 0;
    compares  = 0;
    // Single chip: everything released, directions clear
    do_reset(MODE_SINGLE);
    chk("oe_all", {drv_a.oe, drv_b.oe | drv_c.oe}, 16'h0000);
    chk("oe_dg", {drv_d.oe, drv_g.oe, drv_l.oe}, 16'h0000);
    rd(OFS_A_DIR, DIR_RESET);
    rd(OFS_A_DATA, 8'h3C);
    // Port A mixed direction
    wr(OFS_A_DIR, 8'h0F);
    wr(OFS_A_DATA, 8'h5A);
    settle();
    chk("a_drive", {drv_a.oe, drv_a.out & 8'h0F}, 16'h0F0A);
    rd(OFS_A_DATA, 8'h3A);
    chk("capture", {8'h00, cap_lvl}, 16'h003A);
    // Compare-owned bits ignore data writes
    @(posedge clock);
    tc_en  <= TIMER_OC_MASK;
    tc_lvl <= 8'hA8;
    wr(OFS_A_DIR, 8'hFF);
    wr(OFS_A_DATA, 8'h07);
    settle();
    chk("a_compare", {drv_a.oe, drv_a.out}, 16'hFFAF);
    // Ports B and C as plain outputs, pull-ups, then open drain
    wr(OFS_B_DIR, 8'hFF);
    wr(OFS_B_DATA, 8'hC3);
    wr(OFS_OPTION, 8'h02);
    settle();
    chk("b_drive", {drv_b.out, drv_b.oe}, 16'hC3FF);
    chk("pullup", {15'h0000, pu_en}, 16'h0001);
    wr(OFS_C_DIR, 8'hFF);
    wr(OFS_C_DATA, 8'h0F);
    wr(OFS_OPTION, 8'h01);
    settle();
    chk("c_open", {drv_c.oe, drv_c.out & drv_c.oe}, 16'hF000);
    // Port D latch, then serial owning bits 1:0
    wr(OFS_D_DIR, 8'h3F);
    wr(OFS_D_DATA, 8'h2A);
    settle();
    chk("d_drive", {drv_d.out, drv_d.oe}, {4'h0, 6'h2A, 6'h3F});
    @(posedge clock);
    s_en  <= 6'h03;
    s_alt <= {6'h3D, 6'h02};
    settle();
    chk("d_alt", {drv_d.out, drv_d.oe}, {4'h0, 6'h29, 6'h3E});
    rd(OFS_D_DATA, 8'h29);
    chk("serial_level", {10'h000, s_lvl}, 16'h0029);
    // Port E input only
    wr(OFS_E_DATA, 8'h00);
    rd(OFS_E_DATA, 8'h96);
    chk("analog", {8'h00, an_lvl}, 16'h0096);
    // Shared pin as port bit 7
    wr(OFS_G_DIR, 8'h80);
    wr(OFS_G_DATA, 8'h80);
    settle();
    chk("g7_drive", {14'h0000, drv_g.out, drv_g.oe}, 16'h0003);
    rd(8'h30, ZERO_BYTE);
    rd(OFS_MODE, 8'h00);
    // Expanded: C starts as bus, latches stay off the pins
    do_reset(MODE_EXPANDED);
    rd(OFS_MODE, 8'h01);
    rd(OFS_C_DIR, DIR_RESET);
    wr(OFS_C_DIR, 8'hFF);
    wr(OFS_C_DATA, 8'h55);
    wr(OFS_OPTION, 8'h01);
    settle();
    chk("c_idle", {drv_c.oe, 7'h00, drv_g.out}, 16'h0001);
    @(posedge clock);
    bus_act  <= 1'b1;
    bus_addr <= 16'hBEEF;
    bus_wd   <= 8'hC4;
    settle();
    chk("hi_addr", {drv_b.out, drv_b.oe}, 16'hBEFF);
    chk("lo_addr", {drv_l.out, drv_l.oe}, 16'hEFFF);
    chk("wr_data", {drv_c.out, drv_c.oe}, 16'hC4FF);
    chk("rw_write", {14'h0000, drv_g.out, drv_g.oe}, 16'h0001);
    @(posedge clock);
    bus_rdc <= 1'b1;
    ext_c   <= 8'h77;
    settle();
    chk("rw_read", {drv_c.oe, 6'h00, drv_g.out, drv_g.oe}, 16'h0003);
    chk("bus_rdata", {8'h00, bus_rd}, 16'h0077);
    rd(OFS_C_DATA, 8'h77);
    @(posedge clock);
    bus_act <= 1'b0;
    // Bootstrap: plain outputs, open drain has no effect
    do_reset(MODE_BOOT);
    wr(OFS_C_DIR, 8'hFF);
    wr(OFS_C_DATA, 8'h0F);
    wr(OFS_OPTION, 8'h01);
    settle();
    chk("c_boot", {drv_c.out, drv_c.oe}, 16'h0FFF);
    chk("g7_boot", {15'h0000, drv_g.oe}, 16'h0000);
    // Test mode: bus functions as in expanded mode
    do_reset(MODE_TEST);
    rd(OFS_MODE, 8'h03);
    @(posedge clock);
    bus_act  <= 1'b1;
    bus_rdc  <= 1'b0;
    bus_addr <= 16'h1234;
    bus_wd   <= 8'h6B;
    settle();
    chk("test_addr", {drv_b.out, drv_l.out}, 16'h1234);
    chk("test_write", {drv_c.out, 6'h00, drv_g.out, drv_g.oe}, 16'h6B01);
    @(posedge clock);
    bus_act <= 1'b0;
    report_and_stop();
  end
endmodule
